// >>> logic/sdram_dev.sv
/*
 * synchronous dram device: row activation, read and write bursts,
 * truncation, data mask, auto precharge; plus a write buffer fifo.
 * assumes the controller shares ref_clk and meets the row timings.
 */
`timescale 1ns/1ps

// =====================================================
// write buffer fifo
module wbuf_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("depth must be a power of two");

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [PW:0]             cnt;
        logic                    full;
        logic                    empty;
    } fst_t;

    fst_t st_r;
    fst_t st_nxt;
    logic push;
    logic pop;

    always_comb begin
        st_nxt = st_r;
        push   = in_valid & ~st_r.full;
        pop    = out_ready & ~st_r.empty;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp           = st_r.wp + 1'b1;
        end
        if (pop) st_nxt.rp = st_r.rp + 1'b1;
        st_nxt.cnt   = st_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        st_nxt.full  = st_nxt.cnt == (PW+1)'(DEPTH);
        st_nxt.empty = st_nxt.cnt == '0;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r       <= '0;
            st_r.empty <= 1'b1;
        end else st_r <= st_nxt;
    end

    assign in_ready  = ~st_r.full;
    assign out_valid = ~st_r.empty;
    assign out_data  = st_r.mem[st_r.rp];
endmodule

// =====================================================
// device core
// Summary of operation
// - read data appears cas latency clocks after read, one per clock.
// - completed read burst with no new command releases the data pins.
// - full-page bursts run until stopped, wrapping to their start column.
// - a new read truncates or follows a read seamlessly.
// - reads are accepted every clock to any open bank.
// - a write may truncate or follow a read burst.
// - a registered write forces pins off if mask was high before.
// - auto precharge per command closes the bank at burst end.
// - write data captured on the command edge, then each edge.
// - after a fixed write burst input data is ignored.
// - a new write truncates the previous one and takes its data.
// - address bit ten selects auto precharge, bank inputs pick bank.
// - mask high on reads turns the pins off two clocks later.
module sdram_dev #(
    parameter int DW    = 16,
    parameter int ROW_W = 2,
    parameter int COL_W = 3
) (
    input  wire logic                          ref_clk,
    input  wire logic                          srst,
    input  wire logic                          cs_n,
    input  wire logic                          ras_n,
    input  wire logic                          cas_n,
    input  wire logic                          we_n,
    input  wire logic [1:0]                    ba,
    input  wire logic [sdram_pkg::ADDR_W-1:0]  addr,
    input  wire logic                          dqm,
    input  wire logic [DW-1:0]                 dq_in,
    output logic      [DW-1:0]                 dq_out,
    output logic                               dq_oe,
    input  wire logic [2:0]                    bl_sel,
    input  wire logic [1:0]                    cas_latency,
    output logic      [sdram_pkg::BANKS-1:0]   bank_open,
    output logic                               wbuf_ready
);
    localparam int IW = 2 + ROW_W + COL_W;
    localparam int NW = 1 << IW;
    if (COL_W < 3 || COL_W > 10 || ROW_W < 1 || ROW_W > 13)
        $error("row or column width out of range");

    typedef struct packed {
        logic [sdram_pkg::BANKS-1:0]            open;
        logic [sdram_pkg::BANKS-1:0][ROW_W-1:0] row;
        logic                                   rd_act;
        logic                                   wr_act;
        logic                                   ap;
        logic                                   full;
        logic [1:0]                             bank;
        logic [COL_W-1:0]                       base;
        logic [COL_W-1:0]                       col;
        logic [COL_W-1:0]                       left;
        logic [1:0]                             pv;
        logic [1:0][DW-1:0]                     pd;
        logic                                   dqm;
        logic                                   oe;
        logic [DW-1:0]                          dout;
        logic [NW-1:0][DW-1:0]                  mem;
    } st_t;

    st_t                 st_r;
    st_t                 st_nxt;
    sdram_pkg::cmd_t     cmd;
    logic                new_rd;
    logic                new_wr;
    logic                kill;
    logic                go;
    logic                fetch;
    logic                push;
    logic [COL_W-1:0]    m;
    logic [IW-1:0]       idx;
    logic                f_valid;
    logic [IW+DW-1:0]    f_data;

    // burst wrap mask: fixed lengths wrap inside their aligned block
    function automatic logic [COL_W-1:0] blen_mask(input logic [2:0] sel);
        logic [COL_W-1:0] r;
        r = '1;
        if (sel <= 3'h3) r = COL_W'((1 << sel) - 1);
        return r;
    endfunction

    assign cmd = sdram_pkg::decode(cs_n, ras_n, cas_n, we_n);

    always_comb begin
        st_nxt = st_r;
        m      = blen_mask(bl_sel);
        fetch  = 1'b0;
        push   = 1'b0;
        // output stage picks the pipe tap for the latency, gated by mask
        if (cas_latency == sdram_pkg::CL_THREE) begin
            st_nxt.oe   = st_r.pv[1] & ~st_r.dqm;
            st_nxt.dout = st_r.pd[1];
        end else begin
            st_nxt.oe   = st_r.pv[0] & ~st_r.dqm;
            st_nxt.dout = st_r.pd[0];
        end
        st_nxt.pv    = {st_r.pv[0], 1'b0};
        st_nxt.pd[1] = st_r.pd[0];
        st_nxt.dqm   = dqm;
        new_rd = cmd == sdram_pkg::CMD_RD && st_r.open[ba];
        // unmasked read data still in flight makes the write invalid
        new_wr = cmd == sdram_pkg::CMD_WR && st_r.open[ba]
                 && !((st_r.rd_act || (|st_r.pv)) && !st_r.dqm);
        kill = cmd == sdram_pkg::CMD_BST || new_rd || new_wr
               || (cmd == sdram_pkg::CMD_PRE
                   && (addr[sdram_pkg::AP_BIT] || ba == st_r.bank));
        go = new_rd || new_wr || ((st_r.rd_act || st_r.wr_act) && !kill);
        if (kill) begin
            st_nxt.rd_act = 1'b0;
            st_nxt.wr_act = 1'b0;
        end
        if (cmd == sdram_pkg::CMD_ACT) begin
            st_nxt.open[ba] = 1'b1;
            st_nxt.row[ba]  = addr[ROW_W-1:0];
        end
        if (cmd == sdram_pkg::CMD_PRE) begin
            if (addr[sdram_pkg::AP_BIT]) st_nxt.open = '0;
            else st_nxt.open[ba] = 1'b0;
        end
        if (new_wr) begin
            st_nxt.oe = 1'b0;
            st_nxt.pv = '0;
        end
        if (new_rd || new_wr) begin
            st_nxt.rd_act = new_rd;
            st_nxt.wr_act = new_wr;
            st_nxt.bank   = ba;
            st_nxt.base   = addr[COL_W-1:0];
            st_nxt.col    = addr[COL_W-1:0];
            st_nxt.full   = bl_sel == sdram_pkg::BL_FULL;
            // auto precharge has no meaning for full-page bursts
            st_nxt.ap     = addr[sdram_pkg::AP_BIT] && bl_sel != sdram_pkg::BL_FULL;
            st_nxt.left   = m;
        end
        idx = {st_nxt.bank, st_nxt.row[st_nxt.bank], st_nxt.col};
        if (go && st_nxt.rd_act) begin
            fetch           = 1'b1;
            st_nxt.pv[0]    = 1'b1;
            st_nxt.pd[0]    = st_r.mem[idx];
        end
        if (go && st_nxt.wr_act) push = !dqm;
        if (go) begin
            if (!st_nxt.full && st_nxt.left == '0) begin
                st_nxt.rd_act = 1'b0;
                st_nxt.wr_act = 1'b0;
                if (st_nxt.ap) st_nxt.open[st_nxt.bank] = 1'b0;
            end else begin
                st_nxt.left = st_nxt.left - 1'b1;
                if (st_nxt.full) begin
                    if (st_nxt.col == '1) st_nxt.col = st_nxt.base;
                    else st_nxt.col = st_nxt.col + 1'b1;
                end else begin
                    st_nxt.col = (st_nxt.col & ~m) | ((st_nxt.col + 1'b1) & m);
                end
            end
        end
        // array is single ported: buffered writes drain only when no read fetch
        if (f_valid && !fetch) st_nxt.mem[f_data[IW+DW-1:DW]] = f_data[DW-1:0];
    end

    always_ff @(posedge ref_clk) begin
        if (srst) st_r <= '0;
        else st_r <= st_nxt;
    end

    // full buffer drops write data; controller watches wbuf_ready
    wbuf_fifo #(
        .W     (IW + DW),
        .DEPTH (sdram_pkg::WBUF_DEPTH)
    ) u_wbuf (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_valid  (push),
        .in_ready  (wbuf_ready),
        .in_data   ({idx, dq_in}),
        .out_valid (f_valid),
        .out_ready (!fetch),
        .out_data  (f_data)
    );

    assign dq_out    = st_r.dout;
    assign dq_oe     = st_r.oe;
    assign bank_open = st_r.open;

    // =====================================================
    // checks
    sequence rd3_s;
        new_rd && cas_latency == sdram_pkg::CL_THREE
        ##1 !dqm && cmd != sdram_pkg::CMD_WR;
    endsequence
    sequence rd1_end_s;
        new_rd && bl_sel == sdram_pkg::BL_ONE && cas_latency == sdram_pkg::CL_TWO
        ##1 cmd == sdram_pkg::CMD_NOP;
    endsequence

    read_lat_two_a: assert property (@(posedge ref_clk) disable iff (srst)
        new_rd && cas_latency == sdram_pkg::CL_TWO && !dqm |-> ##2 dq_oe)
        else $error("read data missing at latency two");
    read_lat_three_a: assert property (@(posedge ref_clk) disable iff (srst)
        rd3_s |-> ##2 dq_oe)
        else $error("read data missing at latency three");
    read_mask_a: assert property (@(posedge ref_clk) disable iff (srst)
        dqm |-> ##2 !dq_oe)
        else $error("masked read data driven");
    write_hiz_a: assert property (@(posedge ref_clk) disable iff (srst)
        new_wr |-> ##1 !dq_oe)
        else $error("pins driven after write");
    read_end_a: assert property (@(posedge ref_clk) disable iff (srst)
        rd1_end_s |-> ##2 !dq_oe)
        else $error("pins not released after burst");
    auto_close_a: assert property (@(posedge ref_clk) disable iff (srst)
        new_rd && addr[sdram_pkg::AP_BIT] && bl_sel == sdram_pkg::BL_ONE
        |=> !bank_open[$past(ba)])
        else $error("auto precharge did not close bank");
    write_end_a: assert property (@(posedge ref_clk) disable iff (srst)
        new_wr && bl_sel == sdram_pkg::BL_TWO ##1 cmd == sdram_pkg::CMD_NOP
        |=> !st_r.wr_act)
        else $error("write burst overran its length");
    write_cap_a: assert property (@(posedge ref_clk) disable iff (srst)
        new_wr && !dqm |-> push)
        else $error("first write element not captured");
endmodule

// >>> logic/sdram_pkg.sv
/*
 * shared constants for the synchronous dram device model: command
 * decode, burst length codes, cas latency codes, buffer depth.
 * assumes one rising-edge clock shared with the memory controller.
 */
package sdram_pkg;
    // =====================================================
    // commands
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_BST, CMD_OTHER
    } cmd_t;

    // =====================================================
    // field positions and codes
    localparam int         BANKS       = 4;
    localparam int         ADDR_W      = 13;
    localparam int         AP_BIT      = 10;
    localparam logic [2:0] BL_ONE      = 3'h0;
    localparam logic [2:0] BL_TWO      = 3'h1;
    localparam logic [2:0] BL_FULL     = 3'h7;
    localparam logic [1:0] CL_TWO      = 2'h2;
    localparam logic [1:0] CL_THREE    = 2'h3;
    localparam int         WBUF_DEPTH  = 16;

    // deselected (cs high) reads as nop
    function automatic cmd_t decode(input logic cs_n, input logic ras_n,
                                    input logic cas_n, input logic we_n);
        cmd_t c;
        c = CMD_OTHER;
        if (cs_n) c = CMD_NOP;
        else begin
            case ({ras_n, cas_n, we_n})
                3'h7: c = CMD_NOP;
                3'h3: c = CMD_ACT;
                3'h5: c = CMD_RD;
                3'h4: c = CMD_WR;
                3'h2: c = CMD_PRE;
                3'h6: c = CMD_BST;
                default: c = CMD_OTHER;
            endcase
        end
        return c;
    endfunction
endpackage

// >>> verification/ctrl_model.sv
/* memory controller model: drives command, bank, address, mask and write data pins.
   assumes the bench calls its tasks; every pin changes at the falling edge. */
`timescale 1ns/1ps
// =====================================================
// controller side of the command link
module ctrl_model #(
    parameter int RCD_CLK = 2,
    parameter int RP_CLK  = 2
) (
    input  wire logic        ref_clk,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [1:0]       ba,
    output logic [12:0]      addr,
    output logic             dqm,
    output logic [15:0]      dq_in
);
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 2'h0;
        addr = 13'h0;
        dqm = 1'b0;
        dq_in = 16'h0;
    end
    task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a,
                       input logic [15:0] d, input logic m);
        @(negedge ref_clk);
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = rcw;
        ba = b;
        addr = a;
        dq_in = d;
        dqm = m;
    endtask
    // idle cycles mix deselect and nop with random bank, address and data,
    // so the device must ignore everything but a selected command
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge ref_clk);
            cs_n                 = 1'($urandom_range(1));
            {ras_n, cas_n, we_n} = cs_n ? 3'($urandom) : 3'h7;
            ba                   = 2'($urandom);
            addr                 = 13'($urandom);
            dq_in                = 16'($urandom);
            dqm                  = 1'b0;
        end
    endtask
    task automatic open_row(input logic [1:0] b);
        cmd(3'h3, b, 13'h0, ~dq_in, 1'b0);
        idle(RCD_CLK + RP_CLK);
    endtask
endmodule

// >>> verification/sdram_activate_read_write_bursts_tb.sv
/* self-checking bench for the sdram device: bursts, truncation, mask, precharge.
   assumes ctrl_model drives the pins; read data checked against a shadow row. */
`timescale 1ns/1ps
module sdram_activate_read_write_bursts_tb;
    localparam logic [2:0] RD = 3'h5;
    localparam logic [2:0] WR = 3'h4;
    localparam logic [2:0] PRE = 3'h2;
    localparam logic [2:0] BST = 3'h6;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        cs_n, ras_n, cas_n, we_n, dqm, dq_oe, wbuf_ready;
    logic [1:0]  ba, cas_latency;
    logic [12:0] addr;
    logic [15:0] dq_in, dq_out;
    logic [2:0]  bl_sel;
    logic [3:0]  bank_open;
    logic [15:0] mem [8];
    logic [15:0] exp_q [$];
    int          mismatches = 0;
    int          checks_done = 0;
    always #2.5 ref_clk = ~ref_clk;
    ctrl_model u_ctl (.ref_clk(ref_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));
    sdram_dev u_dut (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .bl_sel(bl_sel), .cas_latency(cas_latency),
        .bank_open(bank_open), .wbuf_ready(wbuf_ready));
    // =====================================================
    // reporting
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic fail(input string s);
        mismatches++;
        $display("mismatch at %0t: %s", $time, s);
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g, input string s);
        checks_done++;
        if (g !== e) fail(s);
    endtask
    // every driven read element must match the oldest note
    always @(posedge ref_clk) begin
        if (!srst && dq_oe === 1'b1) begin
            if (exp_q.size() == 0) fail("read data with none expected");
            else chk(exp_q.pop_front(), dq_out, "read data");
        end
    end
    // =====================================================
    // stimulus helpers
    task automatic rd(input logic [1:0] b, input logic [12:0] a);
        u_ctl.cmd(RD, b, a, ~dq_in, 1'b0);
    endtask
    task automatic wr(input int col, input int n);
        for (int i = 0; i < n; i++) begin
            mem[col + i] = 16'($urandom);
            u_ctl.cmd((i == 0) ? WR : 3'h7, 2'h0, 13'(col), mem[col + i], 1'b0);
        end
    endtask
    task automatic expect_cols(input int c0, input int c1, input int c2, input int c3);
        int cs [4];
        cs = '{c0, c1, c2, c3};
        foreach (cs[i]) if (cs[i] >= 0) exp_q.push_back(mem[cs[i]]);
    endtask
    // also idles long enough for the write buffer to empty
    task automatic drain(input string name);
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 40) begin
            // keep issuing idles: held pins would repeat the last command
            u_ctl.idle(1);
            n++;
        end
        if (exp_q.size() != 0) begin
            fail("read data never came");
            print_verdict();
        end
        u_ctl.idle(20);
        $display("test %s done", name);
    endtask
    // =====================================================
    // main sequence
    initial begin
        void'($urandom(32'he806));
        cas_latency = 2'h2;
        bl_sel = 3'h3;
        repeat (4) @(negedge ref_clk);
        srst = 1'b0;
        chk(16'h1, 16'({bank_open, dq_oe, wbuf_ready}), "reset state");
        u_ctl.open_row(2'h0);
        chk(16'h1, 16'(bank_open), "row open");
        wr(0, 8);
        bl_sel = 3'h1;
        wr(0, 1);
        wr(2, 2);
        drain("write bursts");
        bl_sel = 3'h2;
        for (int cl = 2; cl <= 3; cl++) begin
            cas_latency = 2'(cl);
            expect_cols(2, 3, 0, 1);
            rd(2'h0, 13'h2);
            drain("latency");
        end
        cas_latency = 2'h2;
        expect_cols(0, 4, 5, 6);
        expect_cols(7, -1, -1, -1);
        rd(2'h0, 13'h0);
        rd(2'h0, 13'h4);
        drain("read to read");
        bl_sel = 3'h7;
        expect_cols(5, 6, 7, 5);
        expect_cols(6, -1, -1, -1);
        rd(2'h0, 13'h5);
        u_ctl.idle(4);
        u_ctl.cmd(BST, 2'h0, 13'h0, ~dq_in, 1'b0);
        drain("full page stop");
        bl_sel = 3'h2;
        expect_cols(0, 2, 3, -1);
        rd(2'h0, 13'h0);
        u_ctl.cmd(3'h7, 2'h0, 13'h0, ~dq_in, 1'b1);
        drain("read mask");
        bl_sel = 3'h3;
        expect_cols(0, -1, -1, -1);
        rd(2'h0, 13'h0);
        u_ctl.cmd(3'h7, 2'h0, 13'h0, ~dq_in, 1'b1);
        u_ctl.cmd(3'h7, 2'h0, 13'h0, ~dq_in, 1'b1);
        wr(0, 8);
        drain("read to write");
        expect_cols(0, 1, 2, -1);
        rd(2'h0, 13'h0);
        u_ctl.idle(2);
        u_ctl.cmd(PRE, 2'h0, 13'h0, ~dq_in, 1'b0);
        drain("read to precharge");
        chk(16'h0, 16'(bank_open), "precharge closes");
        rd(2'h0, 13'h0);
        u_ctl.open_row(2'h1);
        bl_sel = 3'h1;
        exp_q.push_back(16'h0);
        exp_q.push_back(16'h0);
        rd(2'h1, 13'h400);
        drain("auto precharge");
        chk(16'h0, 16'(bank_open), "auto close");
        u_ctl.open_row(2'h1);
        bl_sel = 3'h0;
        exp_q.push_back(16'h0);
        rd(2'h1, 13'h401);
        drain("single auto precharge");
        chk(16'h0, 16'(bank_open), "single close");
        u_ctl.open_row(2'h0);
        u_ctl.open_row(2'h2);
        u_ctl.cmd(PRE, 2'h3, 13'h400, ~dq_in, 1'b0);
        u_ctl.idle(1);
        chk(16'h0, 16'(bank_open), "precharge all");
        chk(16'h1, 16'(wbuf_ready), "buffer ready");
        print_verdict();
    end
endmodule
